// ===== design/isp_port.sv
// Serial in-system programming port with code array and lock bits
`timescale 1ns/1ps
`default_nettype none
module isp_port #(
  parameter int ERASE_CYCLES = isp_port_pkg::ERASE_CYCLES,
  parameter int WRITE_CYCLES = isp_port_pkg::WRITE_CYCLES,
  parameter logic [7:0] SIG0 = 8'h11, // Arbitrary identity value
  parameter logic [7:0] SIG1 = 8'h22, // Arbitrary identity value
  parameter logic [7:0] SIG2 = 8'h33  // Arbitrary identity value
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Programming pins
  input wire logic resetPin,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  // Status
  output logic progActive,
  output logic busy,
  output logic [2:0] lockState,
  output logic cpuRun
);
  localparam int AW = isp_port_pkg::ADDR_W;
  localparam int HW = isp_port_pkg::HI_W;
  localparam int CW = isp_port_pkg::CNT_W;

  typedef struct packed {
    logic sckM, sckA, sckB, sckLvl;
    logic mosiM, mosiA, mosiB, mosiLvl;
    logic rstM, rstA, rstB, rstLvl;
    logic progEn;
    logic [7:0] shIn;
    logic [2:0] bitCnt;
    logic [1:0] byteIdx;
    logic [7:0] op;
    logic [7:0] b2;
    logic [7:0] b3;
    logic pageMode;
    logic pageWr;
    logic [8:0] pageCnt;
    logic [7:0] outSh;
    logic miso;
    logic [2:0] lock;
    logic [CW-1:0] busyCnt;
    logic busy;
    logic erasing;
    logic [AW-1:0] eraseAddr;
    logic [AW-1:0] lastAddr;
    logic [7:0] lastData;
    logic run;
  } state_type;

  state_type s_q, s_d;
  logic rise, fall, byteDone;
  logic memWe;
  logic [AW-1:0] memAddr;
  logic [7:0] memData;
  logic [7:0] mem [0:(1<<AW)-1];

  // Next state of the whole port
  always_comb begin
    logic [7:0] byteIn;
    logic [AW-1:0] rdAddr;
    logic [7:0] rdData;
    byteIn = '0;
    rdAddr = '0;
    rdData = '0;
    s_d = s_q;
    memWe = 1'b0;
    memAddr = '0;
    memData = '0;
    // Three-stage synchronisers; a change counts once stages two and three agree
    s_d.sckM = sck;
    s_d.sckA = s_q.sckM;
    s_d.sckB = s_q.sckA;
    s_d.mosiM = mosi;
    s_d.mosiA = s_q.mosiM;
    s_d.mosiB = s_q.mosiA;
    s_d.rstM = resetPin;
    s_d.rstA = s_q.rstM;
    s_d.rstB = s_q.rstA;
    if (s_q.sckA == s_q.sckB) s_d.sckLvl = s_q.sckB;
    if (s_q.mosiA == s_q.mosiB) s_d.mosiLvl = s_q.mosiB;
    if (s_q.rstA == s_q.rstB) s_d.rstLvl = s_q.rstB;
    // Edge finding needs phases of at least 2 clocks to see every edge
    rise = s_q.rstLvl && !s_q.sckLvl && s_q.sckA == s_q.sckB && s_q.sckB;
    fall = s_q.rstLvl && s_q.sckLvl && s_q.sckA == s_q.sckB && !s_q.sckB;
    byteDone = rise && s_q.bitCnt == isp_port_pkg::LAST_BIT;
    // Self-timed write and erase cycles
    if (s_q.busyCnt != '0) s_d.busyCnt = s_q.busyCnt - CW'(1);
    if (s_q.erasing) begin
      memWe = 1'b1;
      memAddr = s_q.eraseAddr;
      memData = isp_port_pkg::ERASED;
      s_d.eraseAddr = s_q.eraseAddr + AW'(1);
      if (s_q.eraseAddr == '1) s_d.erasing = 1'b0;
    end
    s_d.run = !s_q.rstLvl;
    if (!s_q.rstLvl) begin
      // Reset pin low ends the session
      s_d.progEn = 1'b0;
      s_d.bitCnt = '0;
      s_d.byteIdx = isp_port_pkg::IDX_OP;
      s_d.pageMode = 1'b0;
      s_d.outSh = '0;
      s_d.miso = 1'b0;
    end else begin
      // Output shifts on the falling edge, MSB first
      if (fall) begin
        s_d.miso = s_q.outSh[7];
        s_d.outSh = {s_q.outSh[6:0], 1'b0};
      end
      if (rise) begin
        byteIn = {s_q.shIn[6:0], s_q.mosiLvl};
        s_d.shIn = byteIn;
        s_d.bitCnt = s_q.bitCnt + 3'h1;
      end
      if (byteDone && s_q.pageMode) begin
        // Page data stream, bytes 0 to 255 of the page
        rdAddr = {s_q.b2[HW-1:0], s_q.pageCnt[7:0]};
        s_d.pageCnt = s_q.pageCnt + 9'h001;
        if (s_q.pageWr) begin
          // Array port untouched while busy so an erase sweep is not hijacked
          if (!s_q.busy) begin
            memWe = 1'b1;
            memAddr = rdAddr;
            memData = byteIn;
          end
        end else begin
          rdData = mem[rdAddr + AW'(1)];
          s_d.outSh = rdData;
        end
        if (s_q.pageCnt[7:0] == '1) begin
          s_d.pageMode = 1'b0;
          s_d.byteIdx = isp_port_pkg::IDX_OP;
          if (s_q.pageWr && !s_q.busy) begin
            s_d.busyCnt = CW'(WRITE_CYCLES);
            s_d.lastAddr = rdAddr;
            s_d.lastData = byteIn;
          end
        end
      end else if (byteDone) begin
        s_d.byteIdx = s_q.byteIdx + 2'h1;
        unique case (s_q.byteIdx)
          isp_port_pkg::IDX_OP: s_d.op = byteIn;
          isp_port_pkg::IDX_B2: begin
            s_d.b2 = byteIn;
            if (s_q.progEn && (s_q.op == isp_port_pkg::OP_PAGE_RD ||
                s_q.op == isp_port_pkg::OP_PAGE_WR)) begin
              // Command and upper address taken; data follows
              s_d.pageMode = 1'b1;
              s_d.pageWr = s_q.op == isp_port_pkg::OP_PAGE_WR;
              s_d.pageCnt = '0;
              rdAddr = {byteIn[HW-1:0], 8'h00};
              rdData = mem[rdAddr];
              s_d.outSh = rdData;
            end
          end
          isp_port_pkg::IDX_B3: begin
            s_d.b3 = byteIn;
            rdAddr = {s_q.b2[HW-1:0], byteIn};
            rdData = mem[rdAddr];
            // Answer for byte four is loaded before its first fall
            if (s_q.op == isp_port_pkg::OP_SPECIAL &&
                s_q.b2 == isp_port_pkg::ENABLE_KEY) begin
              s_d.outSh = isp_port_pkg::ENABLE_ECHO;
            end else if (!s_q.progEn) begin
              s_d.outSh = '0;
            end else if (s_q.op == isp_port_pkg::OP_READ) begin
              if (s_q.busy && rdAddr == s_q.lastAddr)
                s_d.outSh = {~s_q.lastData[7], s_q.lastData[6:0]};
              else
                s_d.outSh = rdData;
            end else if (s_q.op == isp_port_pkg::OP_LOCK_RD) begin
              s_d.outSh = '0;
              s_d.outSh[isp_port_pkg::LOCK_LSB +: 3] = s_q.lock;
            end else if (s_q.op == isp_port_pkg::OP_SIG) begin
              unique case (byteIn[1:0])
                2'h0: s_d.outSh = SIG0;
                2'h1: s_d.outSh = SIG1;
                2'h2: s_d.outSh = SIG2;
                default: s_d.outSh = '0;
              endcase
            end else begin
              s_d.outSh = '0;
            end
          end
          isp_port_pkg::IDX_B4: begin
            // Execute on the last bit of byte four
            if (s_q.op == isp_port_pkg::OP_SPECIAL &&
                s_q.b2 == isp_port_pkg::ENABLE_KEY) begin
              s_d.progEn = 1'b1;
            end else if (s_q.progEn && !s_q.busy) begin
              if (s_q.op == isp_port_pkg::OP_SPECIAL &&
                  s_q.b2[7:5] == isp_port_pkg::ERASE_TAG) begin
                s_d.erasing = 1'b1;
                s_d.eraseAddr = '0;
                s_d.lock = '0;
                s_d.busyCnt = CW'(ERASE_CYCLES);
              end else if (s_q.op == isp_port_pkg::OP_SPECIAL &&
                  s_q.b2[7:2] == isp_port_pkg::LOCK_TAG) begin
                // Mode 1 leaves the bits alone; order is the programmer's job
                unique case (s_q.b2[1:0])
                  isp_port_pkg::LOCK_MODE2: s_d.lock[0] = 1'b1;
                  isp_port_pkg::LOCK_MODE3: s_d.lock[1] = 1'b1;
                  isp_port_pkg::LOCK_MODE4: s_d.lock[2] = 1'b1;
                  default: s_d.lock = s_q.lock;
                endcase
              end else if (s_q.op == isp_port_pkg::OP_WRITE) begin
                memWe = 1'b1;
                memAddr = {s_q.b2[HW-1:0], s_q.b3};
                memData = byteIn;
                s_d.lastAddr = memAddr;
                s_d.lastData = byteIn;
                s_d.busyCnt = CW'(WRITE_CYCLES);
              end
            end
          end
          default: s_d.byteIdx = isp_port_pkg::IDX_OP;
        endcase
      end
    end
    s_d.busy = s_d.busyCnt != '0 || s_d.erasing;
  end

  // State register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) s_q <= '0;
    else s_q <= s_d;
  end

  // Code array has no reset; contents are undefined until erased or written
  always_ff @(posedge clk) begin
    if (memWe) mem[memAddr] <= memData;
  end

  assign miso = s_q.miso;
  assign progActive = s_q.progEn;
  assign busy = s_q.busy;
  assign lockState = s_q.lock;
  assign cpuRun = s_q.run;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  enable_echo_a: assert property (byteDone && !s_q.pageMode &&
    s_q.byteIdx == isp_port_pkg::IDX_B3 &&
    s_q.op == isp_port_pkg::OP_SPECIAL && s_q.b2 == isp_port_pkg::ENABLE_KEY
    |=> s_q.outSh == isp_port_pkg::ENABLE_ECHO)
    else $error("enable echo not loaded");
  locked_out_a: assert property (!s_q.progEn && !s_q.erasing |-> !memWe)
    else $error("array written before enable");
  erase_start_a: assert property (byteDone && !s_q.pageMode &&
    s_q.byteIdx == isp_port_pkg::IDX_B4 && s_q.progEn && !s_q.busy &&
    s_q.op == isp_port_pkg::OP_SPECIAL &&
    s_q.b2[7:5] == isp_port_pkg::ERASE_TAG
    |=> s_q.erasing && s_q.lock == '0 && s_q.eraseAddr == '0)
    else $error("chip erase not started");
  byte_write_a: assert property (byteDone && !s_q.pageMode &&
    s_q.byteIdx == isp_port_pkg::IDX_B4 && s_q.progEn && !s_q.busy &&
    s_q.op == isp_port_pkg::OP_WRITE
    |-> memWe ##1 s_q.lastData == s_q.shIn &&
    s_q.busyCnt == CW'(WRITE_CYCLES))
    else $error("byte write not performed");
  page_end_a: assert property (byteDone && s_q.pageMode &&
    s_q.pageCnt[7:0] == 8'hFF |=> !s_q.pageMode &&
    s_q.byteIdx == isp_port_pkg::IDX_OP)
    else $error("page mode did not end after 256 bytes");
  reset_exit_a: assert property (!s_q.rstLvl |=> !s_q.progEn && s_q.run)
    else $error("programming mode kept with reset low");
  miso_shift_a: assert property (fall |=> s_q.miso == $past(s_q.outSh[7]))
    else $error("miso not taken from shift register");
  lock_mode2_a: assert property (byteDone && !s_q.pageMode &&
    s_q.byteIdx == isp_port_pkg::IDX_B4 && s_q.progEn && !s_q.busy &&
    s_q.op == isp_port_pkg::OP_SPECIAL &&
    s_q.b2 == {isp_port_pkg::LOCK_TAG, isp_port_pkg::LOCK_MODE2}
    |=> s_q.lock[0])
    else $error("lock bit 1 not set");
  poll_busy_a: assert property (byteDone && !s_q.pageMode &&
    s_q.byteIdx == isp_port_pkg::IDX_B3 && s_q.progEn && s_q.busy &&
    s_q.op == isp_port_pkg::OP_READ &&
    {s_q.b2[HW-1:0], s_q.shIn[6:0], s_q.mosiLvl} == s_q.lastAddr
    |=> s_q.outSh[7] == !s_q.lastData[7])
    else $error("polling read did not invert msb");

  enable_seen_c: cover property (!s_q.progEn ##1 s_q.progEn);
  erase_seen_c: cover property (s_q.erasing ##1 !s_q.erasing);
  page_seen_c: cover property (s_q.pageMode ##1 !s_q.pageMode);
  poll_seen_c: cover property (s_q.busy && byteDone &&
    s_q.op == isp_port_pkg::OP_READ);
endmodule : isp_port
`default_nettype wire

// ===== design/isp_port_pkg.sv
// Constants for the serial in-system programming command port
package isp_port_pkg;
  // System clock and documented timing figures
  localparam int CLK_MHZ = 125;
  localparam int ERASE_TIME_MS = 500;
  localparam int WRITE_TIME_US = 400;
  localparam int WRITE_EXTRA_CLKS = 64;
  // Longest times convert exactly to whole cycles; the write adds 64 extra clocks
  localparam int ERASE_CYCLES = ERASE_TIME_MS * 1000 * CLK_MHZ;
  localparam int WRITE_CYCLES = WRITE_EXTRA_CLKS + WRITE_TIME_US * CLK_MHZ;
  localparam int CNT_W = 26;
  // Array geometry
  localparam int ADDR_W = 12;
  localparam int PAGE_W = 8;
  localparam int HI_W = ADDR_W - PAGE_W;
  // Instruction bytes
  localparam logic [7:0] OP_SPECIAL = 8'hAC;
  localparam logic [7:0] ENABLE_KEY = 8'h53;
  localparam logic [7:0] ENABLE_ECHO = 8'h69;
  localparam logic [2:0] ERASE_TAG = 3'h4;
  localparam logic [5:0] LOCK_TAG = 6'h38;
  localparam logic [7:0] OP_READ = 8'h20;
  localparam logic [7:0] OP_WRITE = 8'h40;
  localparam logic [7:0] OP_LOCK_RD = 8'h24;
  localparam logic [7:0] OP_SIG = 8'h28;
  localparam logic [7:0] OP_PAGE_RD = 8'h30;
  localparam logic [7:0] OP_PAGE_WR = 8'h50;
  // Lock mode codes and readback position
  localparam logic [1:0] LOCK_MODE2 = 2'h1;
  localparam logic [1:0] LOCK_MODE3 = 2'h2;
  localparam logic [1:0] LOCK_MODE4 = 2'h3;
  localparam int LOCK_LSB = 2;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] IDX_OP = 2'h0;
  localparam logic [1:0] IDX_B2 = 2'h1;
  localparam logic [1:0] IDX_B3 = 2'h2;
  localparam logic [1:0] IDX_B4 = 2'h3;
endpackage : isp_port_pkg

// ===== tb/isp_programmer.sv
// Behavioural model of the external serial programmer
`timescale 1ns/1ps
`default_nettype none
module isp_programmer (
  // Pacing clock
  input wire logic clk,
  // Programming pins
  output logic resetPin,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  initial begin
    resetPin = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
  end
  // Ten clocks a phase keeps well inside the sync limits
  task automatic half();
    repeat (10) @(posedge clk);
    #1;
  endtask : half
  // One byte, MSB first; answer taken at the rise
  task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      half();
      sck = 1'b1;
      rx[i] = miso;
      half();
      sck = 1'b0;
    end
  endtask : shift
  // Whole instructions only, four bytes back to back
  task automatic instr(input logic [31:0] w, output logic [7:0] r4);
    for (int b = 3; b >= 0; b--) begin
      shift(w[b*8 +: 8], r4);
    end
  endtask : instr
  // Reset pin high, then SCK low long past the settle time
  task automatic powerUp();
    resetPin = 1'b1;
    sck = 1'b0;
    repeat (70) @(posedge clk);
    #1;
  endtask : powerUp
  // Leaving programming also drops framing
  task automatic powerDown();
    resetPin = 1'b0;
    repeat (10) @(posedge clk);
    #1;
  endtask : powerDown
endmodule : isp_programmer
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the serial programming port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // Short counts keep the run brief
  localparam int ERASE_N = 5000;
  // Write cycle must outlast a whole polling instruction (640 clocks)
  localparam int WRITE_N = 800;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic resetPin, sck, mosi, miso, progActive, busy, cpuRun;
  logic [2:0] lockState;
  logic [7:0] r;
  int fails = 0;
  int checks = 0;
  always #4 clk = ~clk;
  isp_programmer prog (.clk(clk), .resetPin(resetPin), .sck(sck),
    .mosi(mosi), .miso(miso));
  // Identity values are arbitrary
  isp_port #(.ERASE_CYCLES(ERASE_N), .WRITE_CYCLES(WRITE_N),
    .SIG0(8'hA1), .SIG1(8'hB2), .SIG2(8'hC3)) dut (.clk(clk),
    .rst_b(rst_b), .resetPin(resetPin), .sck(sck), .mosi(mosi),
    .miso(miso), .progActive(progActive), .busy(busy),
    .lockState(lockState), .cpuRun(cpuRun));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
    input string what);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // Bounded wait so a stuck busy flag cannot hang the run
  task automatic waitIdle(input int limit);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < limit) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk({7'h00, busy}, 8'h00, "busy stuck");
  endtask : waitIdle
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // Commands before enable are dropped, then enable echoes
  task automatic t_enable();
    prog.powerUp();
    prog.instr(32'h2000_0000, r);
    chk(r, 8'h00, "read before enable");
    chk({7'h00, progActive}, 8'h00, "active early");
    prog.instr(32'hAC53_0000, r);
    chk(r, 8'h69, "enable echo");
    repeat (8) @(posedge clk);
    #1;
    chk({7'h00, progActive}, 8'h01, "not active");
    chk({7'h00, cpuRun}, 8'h00, "run while programming");
    $display("t_enable done");
  endtask : t_enable
  task automatic t_erase();
    prog.instr(32'hAC80_0000, r);
    repeat (8) @(posedge clk);
    #1;
    chk({7'h00, busy}, 8'h01, "erase busy");
    waitIdle(ERASE_N + 4096 + 100);
    prog.instr(32'h2001_2300, r);
    chk(r, 8'hFF, "erased byte");
    $display("t_erase done");
  endtask : t_erase
  // Poll during the write cycle sees the inverted top bit
  task automatic t_byte();
    prog.instr(32'h400A_BC5A, r);
    repeat (8) @(posedge clk);
    #1;
    chk({7'h00, busy}, 8'h01, "write busy");
    prog.instr(32'h200A_BC00, r);
    chk({7'h00, r[7]}, 8'h01, "poll msb");
    waitIdle(WRITE_N + 20);
    prog.instr(32'h200A_BC00, r);
    chk(r, 8'h5A, "byte readback");
    $display("t_byte done");
  endtask : t_byte
  task automatic t_page();
    prog.shift(8'h50, r);
    prog.shift(8'h03, r);
    for (int i = 0; i < 256; i++) begin
      prog.shift(8'(i) ^ 8'h3C, r);
    end
    waitIdle(WRITE_N + 20);
    prog.shift(8'h30, r);
    prog.shift(8'h03, r);
    for (int i = 0; i < 256; i++) begin
      prog.shift(8'h00, r);
      chk(r, 8'(i) ^ 8'h3C, "page byte");
    end
    prog.instr(32'h2003_0500, r);
    chk(r, 8'h39, "decode after page");
    $display("t_page done");
  endtask : t_page
  // Modes applied in ascending order, each read back
  task automatic t_lock();
    logic [2:0] e;
    for (int m = 0; m < 4; m++) begin
      prog.instr({8'hAC, 6'h38, 2'(m), 16'h0000}, r);
      waitIdle(WRITE_N + 20);
      e = 3'((4'h1 << m) - 4'h1);
      prog.instr(32'h2400_0000, r);
      chk(r, {3'h0, e, 2'h0}, "lock readback");
      chk({5'h00, lockState}, {5'h00, e}, "lock state");
    end
    $display("t_lock done");
  endtask : t_lock
  // Signature select in byte three picks one of three identity bytes
  task automatic t_sig();
    prog.instr(32'h2800_0000, r);
    chk(r, 8'hA1, "signature 0");
    prog.instr(32'h2800_0100, r);
    chk(r, 8'hB2, "signature 1");
    prog.instr(32'h2800_0200, r);
    chk(r, 8'hC3, "signature 2");
    $display("t_sig done");
  endtask : t_sig
  task automatic t_exit();
    prog.powerDown();
    chk({7'h00, progActive}, 8'h00, "still active");
    chk({7'h00, cpuRun}, 8'h01, "no run");
    prog.powerUp();
    prog.instr(32'h2003_0500, r);
    chk(r, 8'h00, "read without enable");
    $display("t_exit done");
  endtask : t_exit
  initial begin
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    t_enable();
    t_erase();
    t_byte();
    t_page();
    t_lock();
    t_sig();
    t_exit();
    tally_and_finish();
  end
  // Watchdog about a quarter beyond the expected run time
  initial begin
    #1000000;
    fails++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
